// ---- design/fpmc_pkg.sv ----
// Purpose: shared constants and types of the front-panel motion block
// Assumes: 100 MHz clock, 32-bit register word on a plain port
// Notes: times are kept in ms and turned into cycle counts here
package fpmc_pkg;

	////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int CLK_HZ = 100_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	// both buttons held this long starts a homing move
	localparam int HOME_HOLD_MS = 2000;
	localparam int HOME_HOLD_CYC = HOME_HOLD_MS * CYC_PER_MS;
	// button contact settling time
	localparam int DEBOUNCE_MS = 10;
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
	// half period of every flashing indicator
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CYC_PER_MS;
	// how long the power light flashes after an identify request
	localparam int IDENT_MS = 3000;
	localparam int IDENT_CYC = IDENT_MS * CYC_PER_MS;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam int AW = 6;
	localparam logic [5:0] OFF_CTRL = 6'h00;
	localparam logic [5:0] OFF_STATUS = 6'h04;
	localparam logic [5:0] OFF_IDENT = 6'h08;
	localparam logic [5:0] OFF_SL_VMAX = 6'h0C;
	localparam logic [5:0] OFF_REST_PCT = 6'h10;
	localparam logic [5:0] OFF_JOG_STEP = 6'h14;
	localparam logic [5:0] OFF_JOG_VMAX = 6'h18;
	localparam logic [5:0] OFF_MOVE_VMAX = 6'h1C;
	localparam logic [5:0] OFF_HOME_VMAX = 6'h20;
	localparam logic [5:0] OFF_PRESET_TOP = 6'h24;
	localparam logic [5:0] OFF_PRESET_BOT = 6'h28;
	localparam logic [5:0] OFF_DRV_VEL0 = 6'h2C;
	localparam logic [5:0] OFF_DRV_VEL3 = 6'h38;

	////////////////////////////////////////////////////////////////////////
	// control field positions and reset values
	localparam int CTRL_ABS_BIT = 0;
	localparam int CTRL_LIM_FLASH_BIT = 1;
	localparam int CTRL_IDENT_FLASH_BIT = 2;
	localparam int CTRL_MOVE_LED_BIT = 3;
	localparam int CTRL_FWD_LIM_LSB = 4;
	localparam int CTRL_REV_LIM_LSB = 6;
	localparam logic [31:0] CTRL_RST = 32'h0000_000E;
	localparam logic [31:0] REST_PCT_RST = 32'h0000_0032;
	localparam logic [31:0] VAL_RST = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// coil drive scaling
	localparam logic [11:0] FULL_AMP = 12'hFFF;
	localparam logic [6:0] PCT_FULL = 7'h64;

	////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0]
	{
		LIM_IGNORE = 2'h0,
		LIM_MAKES = 2'h1,
		LIM_BREAKS = 2'h2
	} fpmc_lim_t;

	typedef enum logic
	{
		PROF_MOVE = 1'h0,
		PROF_JOG = 1'h1
	} fpmc_prof_t;

	typedef enum logic [1:0]
	{
		KIND_JOG = 2'h0,
		KIND_GOTO = 2'h1,
		KIND_HOME = 2'h2
	} fpmc_kind_t;

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h1,
		ST_ONE = 4'h2,
		ST_DUAL = 4'h4,
		ST_WAIT = 4'h8
	} fpmc_state_t;

	// one move request towards the profile generator
	typedef struct packed
	{
		logic valid;
		fpmc_kind_t kind;
		logic fwd;
		fpmc_prof_t prof;
		logic [31:0] pos;
		logic [31:0] vmax;
	} fpmc_cmd_t;

	// a velocity demand, two's complement, positive is forward
	typedef struct packed
	{
		logic valid;
		logic [31:0] vel;
		fpmc_prof_t prof;
	} fpmc_vel_t;

	// register port request
	typedef struct packed
	{
		logic [5:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} fpmc_bus_t;

endpackage

// ---- design/fpmc_debounce.sv ----
// Purpose: settle one front-panel button contact
// Assumes: raw input already synchronous to clock
// Notes: output changes only after the input stood still CYC cycles
`timescale 1ns/1ps
module fpmc_debounce #(
	parameter int CYC = fpmc_pkg::DEBOUNCE_CYC
)(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// contact
	input wire logic raw,
	output logic held
);

	if (CYC < 1)
	begin : g_bad_cyc
		$error("debounce count must be at least one");
	end

	logic [31:0] cnt_reg;
	logic held_reg;
	logic differ;
	logic settled;

	////////////////////////////////////////////////////////////////////////
	// any bounce restarts the count, so a chattering contact never passes
	assign differ = raw != held_reg;
	assign settled = differ && (cnt_reg == 32'(CYC - 1));
	assign held = held_reg;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg <= 32'h0000_0000;
			held_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= (differ && !settled) ? cnt_reg + 32'h1 : 32'h0;
			held_reg <= settled ? raw : held_reg; // [R18]
		end
	end

endmodule

// ---- design/fpmc_front_panel.sv ----
// Purpose: front-panel motion control of a stepper controller
// Assumes: all inputs synchronous to clock; profile generator outside
// Notes: settings come over a plain register port, read data next cycle
//
// Functional notes
// [R1] slider at centre commands zero velocity
// [R2] deflection moves that way, capped at slider maximum
// [R3] slider moves use the general move profile
// [R4] full current moving, lower holding current at rest
// [R5] holding setting is percent of full power
// [R6] limit flash option flashes activity light
// [R7] identify option flashes the power light
// [R8] moving option lights activity light steadily
// [R9] each light mode has its own enable
// [R10] relative mode: button jogs its way, jog settings
// [R11] absolute mode: buttons go to their presets
// [R12] presets unused unless absolute mode selected
// [R13] both buttons held two seconds starts homing
// [R14] four drive velocities, same for both directions
// [R15] equal drive velocities are accepted
// [R16] homing uses move profile, own maximum velocity
// [R17] limits configurable makes, breaks or ignored
// [R18] buttons debounced; hold timer needs both held
`timescale 1ns/1ps
module fpmc_front_panel #(
	parameter int HOME_CYC = fpmc_pkg::HOME_HOLD_CYC,
	parameter int DEB_CYC = fpmc_pkg::DEBOUNCE_CYC,
	parameter int FLASH_CYC = fpmc_pkg::FLASH_HALF_CYC,
	parameter int ID_CYC = fpmc_pkg::IDENT_CYC,
	parameter int SL_DEAD = 16,
	parameter int SL_SHIFT = 8
)(
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// register port
	input wire fpmc_pkg::fpmc_bus_t bus,
	output logic [31:0] rd_data,
	// front panel
	input wire logic signed [11:0] slider_pos,
	input wire logic btn_top_raw,
	input wire logic btn_bot_raw,
	// stage
	input wire logic lim_fwd_in,
	input wire logic lim_rev_in,
	input wire logic motor_moving,
	// drive bar graph
	input wire logic bar_click,
	input wire logic [1:0] bar_sel,
	input wire logic bar_rev,
	// motion requests
	output fpmc_pkg::fpmc_cmd_t move_cmd,
	output fpmc_pkg::fpmc_vel_t slider_cmd,
	output fpmc_pkg::fpmc_vel_t bar_cmd,
	// coil drive and lights
	output logic [11:0] coil_amp,
	output logic led_active,
	output logic led_power
);

	if (SL_SHIFT > 16 || SL_DEAD < 0 || SL_DEAD > 2047 || HOME_CYC < 2 ||
		FLASH_CYC < 1 || ID_CYC < 1)
	begin : g_bad_param
		$error("front panel parameters out of range");
	end

	localparam logic [3:0] I_CTRL = fpmc_pkg::OFF_CTRL[5:2];
	localparam logic [3:0] I_STAT = fpmc_pkg::OFF_STATUS[5:2];
	localparam logic [3:0] I_IDENT = fpmc_pkg::OFF_IDENT[5:2];
	localparam logic [3:0] I_FIRST = fpmc_pkg::OFF_SL_VMAX[5:2];
	localparam logic [3:0] I_LAST = fpmc_pkg::OFF_DRV_VEL3[5:2];
	localparam logic [3:0] I_PCT = fpmc_pkg::OFF_REST_PCT[5:2];
	localparam logic [3:0] I_SLV = fpmc_pkg::OFF_SL_VMAX[5:2];
	localparam logic [3:0] I_JSTEP = fpmc_pkg::OFF_JOG_STEP[5:2];
	localparam logic [3:0] I_JVMAX = fpmc_pkg::OFF_JOG_VMAX[5:2];
	localparam logic [3:0] I_MVMAX = fpmc_pkg::OFF_MOVE_VMAX[5:2];
	localparam logic [3:0] I_HVMAX = fpmc_pkg::OFF_HOME_VMAX[5:2];
	localparam logic [3:0] I_PTOP = fpmc_pkg::OFF_PRESET_TOP[5:2];
	localparam logic [3:0] I_PBOT = fpmc_pkg::OFF_PRESET_BOT[5:2];
	localparam logic [3:0] I_DRV0 = fpmc_pkg::OFF_DRV_VEL0[5:2];

	// value registers live in one contiguous window
	function automatic logic is_val(input logic [3:0] idx);
		is_val = idx >= I_FIRST && idx <= I_LAST;
	endfunction

	// limit polarity decode, shared by both switches
	function automatic logic lim_hit(input logic [1:0] cfg,
		input logic pin);
		case (cfg)
			fpmc_pkg::LIM_MAKES: lim_hit = pin;
			fpmc_pkg::LIM_BREAKS: lim_hit = !pin;
			default: lim_hit = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// reset release through two flops
	logic rst_meta_reg;
	logic rst_n_reg;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register file
	logic [31:0] ctrl_reg;
	logic [31:0] val_reg [I_FIRST:I_LAST];
	logic [31:0] rd_data_reg;
	logic [3:0] bus_idx;
	logic [31:0] status_word;
	logic [31:0] rd_word;
	logic ident_wr;

	assign bus_idx = bus.addr[5:2];
	assign ident_wr = bus.wr && bus_idx == I_IDENT;
	// unmapped addresses read zero and ignore writes
	assign rd_word = bus_idx == I_CTRL ? ctrl_reg :
		bus_idx == I_STAT ? status_word :
		is_val(bus_idx) ? val_reg[bus_idx] : 32'h0000_0000;
	assign rd_data = rd_data_reg;

	always_ff @(posedge clock or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			ctrl_reg <= fpmc_pkg::CTRL_RST;
			rd_data_reg <= 32'h0000_0000;
			for (int i = I_FIRST; i <= I_LAST; i++)
				val_reg[i] <= (4'(i) == I_PCT) ?
					fpmc_pkg::REST_PCT_RST : fpmc_pkg::VAL_RST;
		end
		else
		begin
			// read data stands in the one cycle after the strobe
			rd_data_reg <= bus.rd ? rd_word : 32'h0000_0000;
			if (bus.wr && bus_idx == I_CTRL)
				ctrl_reg <= bus.wdata;
			// no uniqueness check: equal drive velocities are fine
			if (bus.wr && is_val(bus_idx))
				val_reg[bus_idx] <= bus.wdata; // [R15]
		end
	end

	logic abs_mode;
	logic lim_flash_en;
	logic ident_en;
	logic move_led_en;
	logic [1:0] fwd_cfg;
	logic [1:0] rev_cfg;

	assign abs_mode = ctrl_reg[fpmc_pkg::CTRL_ABS_BIT];
	assign lim_flash_en = ctrl_reg[fpmc_pkg::CTRL_LIM_FLASH_BIT];
	assign ident_en = ctrl_reg[fpmc_pkg::CTRL_IDENT_FLASH_BIT];
	assign move_led_en = ctrl_reg[fpmc_pkg::CTRL_MOVE_LED_BIT];
	assign fwd_cfg = ctrl_reg[fpmc_pkg::CTRL_FWD_LIM_LSB +: 2];
	assign rev_cfg = ctrl_reg[fpmc_pkg::CTRL_REV_LIM_LSB +: 2];

	////////////////////////////////////////////////////////////////////////
	// limit switches per their polarity setting
	logic fwd_hit;
	logic rev_hit;

	assign fwd_hit = lim_hit(fwd_cfg, lim_fwd_in); // [R17]
	assign rev_hit = lim_hit(rev_cfg, lim_rev_in); // [R17]

	////////////////////////////////////////////////////////////////////////
	// button settling, one instance per button
	logic [1:0] btn_raw;
	logic [1:0] btn_held;

	assign btn_raw = {btn_bot_raw, btn_top_raw};

	for (genvar b = 0; b < 2; b++)
	begin : g_btn
		fpmc_debounce #(
			.CYC(DEB_CYC)
		) u_deb (
			.clock(clock),
			.rst_n(rst_n_reg),
			.raw(btn_raw[b]),
			.held(btn_held[b])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// button sequencer: a single press acts at once, a dual hold homes
	fpmc_pkg::fpmc_state_t st_reg;
	fpmc_pkg::fpmc_state_t st_next;
	logic [31:0] hold_reg;
	logic both;
	logic any_btn;
	logic hold_done;
	logic press_one;
	logic do_home;

	assign both = &btn_held;
	assign any_btn = |btn_held;
	assign hold_done = hold_reg == 32'(HOME_CYC - 1);
	assign press_one = st_reg == fpmc_pkg::ST_IDLE && any_btn && !both;
	assign do_home = st_reg == fpmc_pkg::ST_DUAL && both && hold_done;

	// a released pair waits for full release so no stray jog follows
	always_comb
	begin
		st_next = st_reg;
		unique case (st_reg)
			fpmc_pkg::ST_IDLE:
				if (both)
					st_next = fpmc_pkg::ST_DUAL;
				else if (any_btn)
					st_next = fpmc_pkg::ST_ONE;
			fpmc_pkg::ST_ONE:
				if (both)
					st_next = fpmc_pkg::ST_DUAL;
				else if (!any_btn)
					st_next = fpmc_pkg::ST_IDLE;
			fpmc_pkg::ST_DUAL:
				if (!both || hold_done)
					st_next = fpmc_pkg::ST_WAIT;
			fpmc_pkg::ST_WAIT:
				if (!any_btn)
					st_next = fpmc_pkg::ST_IDLE;
			default:
				st_next = fpmc_pkg::ST_IDLE;
		endcase
	end

	// hold timer runs only while both settled buttons are held
	always_ff @(posedge clock or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			st_reg <= fpmc_pkg::ST_IDLE;
			hold_reg <= 32'h0000_0000;
		end
		else
		begin
			st_reg <= st_next;
			hold_reg <= (st_reg == fpmc_pkg::ST_DUAL && both) ?
				hold_reg + 32'h1 : 32'h0; // [R18]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// move request for presses and homing
	fpmc_pkg::fpmc_cmd_t cmd_next;
	fpmc_pkg::fpmc_cmd_t cmd_reg;
	logic top_only;

	assign top_only = btn_held[0];

	always_comb
	begin
		cmd_next = '0;
		if (do_home)
		begin
			cmd_next.valid = 1'b1; // [R13]
			cmd_next.kind = fpmc_pkg::KIND_HOME;
			cmd_next.prof = fpmc_pkg::PROF_MOVE; // [R16]
			cmd_next.vmax = val_reg[I_HVMAX]; // [R16]
		end
		else if (press_one && abs_mode)
		begin
			// presets are read only on this branch
			cmd_next.valid = 1'b1;
			cmd_next.kind = fpmc_pkg::KIND_GOTO; // [R11]
			cmd_next.fwd = top_only;
			cmd_next.prof = fpmc_pkg::PROF_MOVE;
			cmd_next.pos = top_only ?
				val_reg[I_PTOP] : val_reg[I_PBOT]; // [R12]
			cmd_next.vmax = val_reg[I_MVMAX];
		end
		else if (press_one)
		begin
			cmd_next.valid = 1'b1;
			cmd_next.kind = fpmc_pkg::KIND_JOG; // [R10]
			cmd_next.fwd = top_only;
			cmd_next.prof = fpmc_pkg::PROF_JOG;
			cmd_next.pos = val_reg[I_JSTEP];
			cmd_next.vmax = val_reg[I_JVMAX];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// slider velocity: dead zone round centre, linear, then capped
	logic [12:0] sl_ext;
	logic [12:0] sl_mag;
	logic sl_centre;
	logic [31:0] sl_raw;
	logic [31:0] sl_cap;
	fpmc_pkg::fpmc_vel_t sl_next;

	assign sl_ext = {slider_pos[11], slider_pos};
	assign sl_mag = sl_ext[12] ? 13'(~sl_ext + 13'h1) : sl_ext;
	assign sl_centre = sl_mag <= 13'(SL_DEAD);
	assign sl_raw = 32'(sl_mag - 13'(SL_DEAD)) << SL_SHIFT;
	assign sl_cap = sl_raw > val_reg[I_SLV] ? val_reg[I_SLV] : sl_raw;
	assign sl_next.valid = !sl_centre;
	assign sl_next.vel = sl_centre ? 32'h0000_0000 : // [R1]
		sl_ext[12] ? 32'(~sl_cap + 32'h1) : sl_cap; // [R2]
	assign sl_next.prof = fpmc_pkg::PROF_MOVE; // [R3]

	////////////////////////////////////////////////////////////////////////
	// drive bar: one table serves both directions
	logic [31:0] bar_mag;
	fpmc_pkg::fpmc_vel_t bar_next;

	assign bar_mag = val_reg[I_DRV0 + {2'h0, bar_sel}]; // [R14]
	assign bar_next.valid = bar_click;
	assign bar_next.vel = bar_rev ? 32'(~bar_mag + 32'h1) : bar_mag;
	assign bar_next.prof = fpmc_pkg::PROF_MOVE;

	////////////////////////////////////////////////////////////////////////
	// coil current: fixed full level moving, percent of full at rest
	logic [6:0] pct_c;
	logic [18:0] amp_prod;
	logic [11:0] amp_rest;
	logic [11:0] amp_next;

	// settings above one hundred percent are clamped, never overdriven
	assign pct_c = val_reg[I_PCT] > 32'(fpmc_pkg::PCT_FULL) ?
		fpmc_pkg::PCT_FULL : val_reg[I_PCT][6:0];
	assign amp_prod = 19'(fpmc_pkg::FULL_AMP) * 19'(pct_c);
	assign amp_rest = 12'(amp_prod / 19'(fpmc_pkg::PCT_FULL)); // [R5]
	assign amp_next = motor_moving ? fpmc_pkg::FULL_AMP : amp_rest; // [R4]

	////////////////////////////////////////////////////////////////////////
	// indicator timing: shared flash phase and identify window
	logic [31:0] flash_cnt_reg;
	logic flash_reg;
	logic [31:0] ident_cnt_reg;
	logic ident_on;
	logic act_next;
	logic pwr_next;

	assign ident_on = ident_cnt_reg != 32'h0000_0000;
	// limit flash outranks the moving light, the stage is stopped there
	assign act_next = (lim_flash_en && (fwd_hit || rev_hit)) ?
		flash_reg : (move_led_en && motor_moving); // [R6] [R8] [R9]
	assign pwr_next = (ident_en && ident_on) ? flash_reg : 1'b1; // [R7]

	always_ff @(posedge clock or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			flash_cnt_reg <= 32'h0000_0000;
			flash_reg <= 1'b0;
			ident_cnt_reg <= 32'h0000_0000;
		end
		else
		begin
			flash_cnt_reg <= (flash_cnt_reg == 32'(FLASH_CYC - 1)) ?
				32'h0 : flash_cnt_reg + 32'h1;
			if (flash_cnt_reg == 32'(FLASH_CYC - 1))
				flash_reg <= !flash_reg;
			// a new request restarts the window
			ident_cnt_reg <= ident_wr ? 32'(ID_CYC) :
				ident_on ? ident_cnt_reg - 32'h1 : 32'h0; // [R7]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output flops
	fpmc_pkg::fpmc_vel_t sl_reg;
	fpmc_pkg::fpmc_vel_t bar_reg;
	logic [11:0] amp_reg;
	logic act_reg;
	logic pwr_reg;

	assign status_word = {26'h0, st_reg == fpmc_pkg::ST_DUAL,
		btn_held, rev_hit, fwd_hit, motor_moving};
	assign move_cmd = cmd_reg;
	assign slider_cmd = sl_reg;
	assign bar_cmd = bar_reg;
	assign coil_amp = amp_reg;
	assign led_active = act_reg;
	assign led_power = pwr_reg;

	always_ff @(posedge clock or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			cmd_reg <= '0;
			sl_reg <= '0;
			bar_reg <= '0;
			amp_reg <= 12'h000;
			act_reg <= 1'b0;
			pwr_reg <= 1'b0;
		end
		else
		begin
			cmd_reg <= cmd_next;
			sl_reg <= sl_next;
			bar_reg <= bar_next;
			amp_reg <= amp_next;
			act_reg <= act_next;
			pwr_reg <= pwr_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n_reg);

	centre_zero_a: assert property (sl_centre |=> // [R1]
		slider_cmd.vel == 32'h0 && !slider_cmd.valid)
		else $error("slider at centre gave nonzero velocity");
	slider_cap_a: assert property (!sl_centre && !sl_ext[12] && // [R2]
		val_reg[I_SLV] != 32'h0 |=>
		slider_cmd.vel <= $past(val_reg[I_SLV]) && slider_cmd.vel != 0)
		else $error("slider velocity over its cap");
	slider_prof_a: assert property (slider_cmd.prof == // [R3]
		fpmc_pkg::PROF_MOVE)
		else $error("slider used a non-move profile");
	move_amp_a: assert property (motor_moving |=> // [R4]
		coil_amp == fpmc_pkg::FULL_AMP)
		else $error("moving without full coil drive");
	rest_amp_a: assert property (!motor_moving && // [R5]
		val_reg[I_PCT] == 32'h0 |=> coil_amp == 12'h000)
		else $error("zero percent rest drive not zero");
	move_led_a: assert property (motor_moving && move_led_en && // [R8]
		!fwd_hit && !rev_hit |=> led_active)
		else $error("moving light off while moving");
	led_off_a: assert property (!lim_flash_en && !move_led_en |=> // [R9]
		!led_active)
		else $error("activity light on with modes disabled");
	ident_flash_a: assert property (ident_wr && ident_en ##1 // [R7]
		(!ident_wr && ident_en) [*2] |=> led_power == $past(flash_reg))
		else $error("power light not following flash phase");
	jog_cmd_a: assert property (press_one && !abs_mode |=> // [R10]
		move_cmd.valid && move_cmd.kind == fpmc_pkg::KIND_JOG &&
		move_cmd.pos == $past(val_reg[I_JSTEP]))
		else $error("relative press did not jog");
	goto_cmd_a: assert property (press_one && abs_mode && // [R11]
		btn_held[0] |=> move_cmd.pos == $past(val_reg[I_PTOP]))
		else $error("top press did not go to its preset");
	home_cmd_a: assert property ($rose(both) && // [R13]
		st_reg != fpmc_pkg::ST_WAIT ##1 both [*2] |-> ##[0:8]
		hold_reg != 32'h0 || move_cmd.kind == fpmc_pkg::KIND_HOME)
		else $error("dual hold timer did not run");
	home_prof_a: assert property (move_cmd.valid && // [R16]
		move_cmd.kind == fpmc_pkg::KIND_HOME |->
		move_cmd.prof == fpmc_pkg::PROF_MOVE &&
		move_cmd.vmax == $past(val_reg[I_HVMAX]))
		else $error("homing request used wrong profile");
	bar_vel_a: assert property (bar_click && !bar_rev |=> // [R14]
		bar_cmd.vel == $past(val_reg[I_DRV0 + {2'h0, bar_sel}]))
		else $error("drive bar velocity mismatch");
	limit_pol_a: assert property (fwd_cfg == fpmc_pkg::LIM_BREAKS && // [R17]
		!lim_fwd_in |-> fwd_hit)
		else $error("breaking limit not detected");

endmodule

// ---- test/fpmc_stage_model.sv ----
// Purpose: behavioural motor stage seen by the front-panel block
// Assumes: every move or bar request keeps the stage busy 20 cycles
// Notes: forward switch closes on contact, reverse switch absent
`timescale 1ns/1ps
module fpmc_stage_model (
	// clock
	input wire logic clock,
	// requests from the block
	input wire fpmc_pkg::fpmc_cmd_t move_cmd,
	input wire fpmc_pkg::fpmc_vel_t bar_cmd,
	// bench puts the carriage on the forward switch
	input wire logic at_fwd,
	// stage status
	output logic motor_moving,
	output logic lim_fwd_in,
	output logic lim_rev_in
);
	int run = 0;

	// a fixed run time keeps moving and resting phases easy to predict
	always @(posedge clock)
	begin
		if (move_cmd.valid || bar_cmd.valid)
			run <= 20;
		else if (run > 0)
			run <= run - 1;
	end

	assign motor_moving = run > 0;
	assign lim_fwd_in = at_fwd;
	assign lim_rev_in = 1'b0;
endmodule

// ---- test/tb.sv ----
// Purpose: self-checking bench of the front-panel motion block
// Assumes: short counts: hold 40, settle 3, flash 4, identify 50
// Notes: results of moves, bars and reads are queued, then matched
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
mismatches++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
	logic clock = 0, resetn = 0, rd_seen = 0, s0, s1;
	fpmc_pkg::fpmc_bus_t bus = '0;
	logic [31:0] rd_data, jog, pt, pb, e32;
	logic signed [11:0] slider_pos = 0;
	logic btn_top_raw = 0, btn_bot_raw = 0, bar_click = 0, bar_rev = 0;
	logic at_fwd = 0, lim_fwd_in, lim_rev_in, motor_moving;
	logic led_active, led_power;
	logic [1:0] bar_sel = 0;
	logic [11:0] coil_amp;
	logic [67:0] e68;
	fpmc_pkg::fpmc_cmd_t move_cmd;
	fpmc_pkg::fpmc_vel_t slider_cmd, bar_cmd;
	logic [31:0] exp_rd[$], exp_bar[$];
	logic [67:0] exp_mv[$];
	int mismatches = 0, total_checks = 0, cyc = 0;

	fpmc_front_panel #(.HOME_CYC(40), .DEB_CYC(3), .FLASH_CYC(4),
		.ID_CYC(50)) fpmc_front_panel_i (.clock(clock), .resetn(resetn),
		.bus(bus), .rd_data(rd_data), .slider_pos(slider_pos),
		.btn_top_raw(btn_top_raw), .btn_bot_raw(btn_bot_raw),
		.lim_fwd_in(lim_fwd_in), .lim_rev_in(lim_rev_in),
		.motor_moving(motor_moving), .bar_click(bar_click),
		.bar_sel(bar_sel), .bar_rev(bar_rev), .move_cmd(move_cmd),
		.slider_cmd(slider_cmd), .bar_cmd(bar_cmd), .coil_amp(coil_amp),
		.led_active(led_active), .led_power(led_power));
	fpmc_stage_model fpmc_stage_model_i (.clock(clock),
		.move_cmd(move_cmd), .bar_cmd(bar_cmd), .at_fwd(at_fwd),
		.motor_moving(motor_moving), .lim_fwd_in(lim_fwd_in),
		.lim_rev_in(lim_rev_in));

	initial
	begin
		forever #5 clock = ~clock;
	end

	task results;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task wt(input int n);
		repeat (n) @(posedge clock);
	endtask

	task wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clock);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask

	task rd(input logic [5:0] a, input logic [31:0] e);
		@(posedge clock);
		bus.addr <= a;
		bus.rd <= 1'b1;
		exp_rd.push_back(e);
		@(posedge clock);
		bus.rd <= 1'b0;
	endtask

	// slider demand settles one cycle after the input
	task sl(input logic signed [11:0] p, input logic signed [31:0] e);
		@(posedge clock);
		slider_pos <= p;
		wt(3);
		`CHK("slider_vel", e, slider_cmd.vel)
		`CHK("slider_valid", e != 0, slider_cmd.valid)
		`CHK("slider_prof", fpmc_pkg::PROF_MOVE, slider_cmd.prof)
	endtask

	// hold buttons until a move shows, then look at the moving phase
	task press(input logic t, input logic b, input int h);
		@(posedge clock);
		btn_top_raw <= t;
		btn_bot_raw <= b;
		for (int i = 0; i < h && move_cmd.valid !== 1'b1; i++)
			@(negedge clock);
		repeat (4) @(negedge clock);
		`CHK("coil_moving", fpmc_pkg::FULL_AMP, coil_amp)
		`CHK("led_moving", 1'b1, led_active)
		@(posedge clock);
		btn_top_raw <= 1'b0;
		btn_bot_raw <= 1'b0;
		wt(30);
		`CHK("coil_rest", 12'h3FF, coil_amp)
	endtask

	// a flashing light must show both levels inside three half periods
	task watch(input logic pw);
		s0 = 0;
		s1 = 0;
		repeat (12) @(negedge clock)
		begin
			if ((pw ? led_power : led_active) === 1'b0) s0 = 1;
			if ((pw ? led_power : led_active) === 1'b1) s1 = 1;
		end
	endtask

	// result watcher and hang limit
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			results;
		end
		if (rd_seen)
		begin
			e32 = exp_rd.pop_front();
			`CHK("rd_data", e32, rd_data)
		end
		rd_seen = bus.rd;
		if (move_cmd.valid === 1'b1)
		begin
			e68 = exp_mv.pop_front();
			`CHK("move_cmd", e68, move_cmd[67:0])
		end
		if (bar_cmd.valid === 1'b1)
		begin
			e32 = exp_bar.pop_front();
			`CHK("bar_vel", e32, bar_cmd.vel)
		end
	end

	initial
	begin
		jog = $urandom(32'h8991);
		pt = $urandom();
		pb = $urandom();
		wt(8);
		resetn <= 1'b1;
		wt(4);
		rd(fpmc_pkg::OFF_CTRL, fpmc_pkg::CTRL_RST);
		rd(fpmc_pkg::OFF_REST_PCT, fpmc_pkg::REST_PCT_RST);
		rd(6'h3C, 32'h0000_0000);
		wt(2);
		`CHK("coil_default", 12'h7FF, coil_amp)
		wr(fpmc_pkg::OFF_SL_VMAX, 32'h0000_2710);
		wr(fpmc_pkg::OFF_JOG_STEP, jog);
		wr(fpmc_pkg::OFF_JOG_VMAX, 32'h0000_0111);
		wr(fpmc_pkg::OFF_MOVE_VMAX, 32'h0000_0222);
		wr(fpmc_pkg::OFF_HOME_VMAX, 32'h0000_0333);
		wr(fpmc_pkg::OFF_PRESET_TOP, pt);
		wr(fpmc_pkg::OFF_PRESET_BOT, pb);
		wr(fpmc_pkg::OFF_REST_PCT, 32'h0000_0019);
		rd(fpmc_pkg::OFF_JOG_STEP, jog);
		sl(12'sd0, 0);
		sl(12'sd16, 0);
		sl(12'sd100, 32'sd10000);
		sl(-12'sd30, -32'sd3584);
		sl(-12'sd2047, -32'sd10000);
		s0 = $urandom_range(1, 0);
		e32 = 32'($urandom_range(37, 17));
		sl(s0 ? -12'(e32) : 12'(e32), (s0 ? -1 : 1) * ((e32 - 16) << 8));
		sl(12'sd0, 0);
		// relative mode: jogs use the jog step, presets stay unused
		exp_mv.push_back({fpmc_pkg::KIND_JOG, 2'b11, jog, 32'h0000_0111});
		press(1, 0, 30);
		exp_mv.push_back({fpmc_pkg::KIND_JOG, 2'b01, jog, 32'h0000_0111});
		press(0, 1, 30);
		wr(fpmc_pkg::OFF_CTRL, 32'h0000_000F);
		// a top press marks its preset move forward, a bottom press not
		exp_mv.push_back({fpmc_pkg::KIND_GOTO, 2'b10, pt, 32'h0000_0222});
		press(1, 0, 30);
		exp_mv.push_back({fpmc_pkg::KIND_GOTO, 2'b00, pb, 32'h0000_0222});
		press(0, 1, 30);
		exp_mv.push_back({fpmc_pkg::KIND_HOME, 34'h0, 32'h0000_0333});
		press(1, 1, 100);
		// two equal velocities are legal
		for (int i = 0; i < 4; i++)
			wr(6'(fpmc_pkg::OFF_DRV_VEL0 + 4 * i), (i < 2) ? 500 : 700 + i);
		for (int i = 0; i < 4; i++)
		begin
			s0 = $urandom_range(1, 0);
			e32 = (i < 2) ? 500 : 700 + i;
			exp_bar.push_back(s0 ? -e32 : e32);
			@(posedge clock);
			bar_click <= 1'b1;
			bar_sel <= 2'(i);
			bar_rev <= s0;
			@(posedge clock);
			bar_click <= 1'b0;
			wt(25);
		end
		// forward switch closing on contact, then opening on contact
		wr(fpmc_pkg::OFF_CTRL, 32'h0000_001E);
		at_fwd <= 1'b1;
		watch(0);
		`CHK("limit_flash", 2'b11, {s0, s1})
		rd(fpmc_pkg::OFF_STATUS, 32'h0000_0002);
		wr(fpmc_pkg::OFF_CTRL, 32'h0000_002E);
		wt(3);
		`CHK("limit_breaks", 1'b0, led_active)
		// an opening switch is hit once its pin drops
		at_fwd <= 1'b0;
		watch(0);
		`CHK("breaks_flash", 2'b11, {s0, s1})
		wr(fpmc_pkg::OFF_IDENT, 32'h0000_0001);
		watch(1);
		`CHK("ident_flash", 2'b11, {s0, s1})
		wr(fpmc_pkg::OFF_CTRL, 32'h0000_0000);
		wr(fpmc_pkg::OFF_IDENT, 32'h0000_0001);
		watch(1);
		`CHK("ident_off", 2'b01, {s0, s1})
		wt(60);
		results;
	end
endmodule
